// ===== rtl/drc_cfg_top.sv
// What this block does
// (R1) Left channel compressed only while left enable bit is set.
// (R2) Right channel compressed only while its own enable bit is set.
// (R3) Threshold code 0..7 means -3 dB down to -24 dB; resets to -12 dB.
// (R4) Hysteresis code means 0..3 dB; resets to 3 dB.
// (R5) Hold code zero disables hold; codes 1..8 give 32..4096 word clocks.
// (R6) Codes 9..13 give longer holds, code 14 wraps to zero (no hold); code 15 gives 163840.
// (R7) Hold code resets to 7, which is 2048 word clocks.
// (R8) Host writes reset values to reserved bits; low hold bits read zero.
// (R9) With compression on, left and right volumes stay independent.
// (R10) Cut gain above threshold, hold, release below threshold minus hysteresis.
`timescale 1ns/100ps
module drc_cfg_top #(
	parameter int SAMPLE_W = 16,
	parameter logic [17:0] HOLD_LONG_PERIODS = 18'h28000
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire drc_pkg::drc_reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	input wire logic word_clk_in,
	input wire logic [1:0] vol_link_in,
	output logic [1:0] vol_link_out,
	input wire logic sample_vld_in,
	input wire logic [SAMPLE_W-1:0] left_sample_in,
	input wire logic [SAMPLE_W-1:0] right_sample_in,
	input wire logic [7:0] left_level_db_in,
	input wire logic [7:0] right_level_db_in,
	output logic [SAMPLE_W-1:0] left_sample_out,
	output logic [SAMPLE_W-1:0] right_sample_out,
	output logic sample_vld_out,
	output logic [1:0] comp_active_out
);
	if (SAMPLE_W < 2) begin : g_bad_width
		$error("sample width must be at least 2");
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [7:0] thr_db(input logic [2:0] code);
		thr_db = 8'(({5'h00, code} + 8'h01) * drc_pkg::THR_STEP_DB); // see (R3)
	endfunction : thr_db

	function automatic logic [17:0] hold_len(input logic [3:0] code);
		if (code == drc_pkg::HOLD_OFF) begin
			hold_len = 18'h00000; // see (R5)
		end else if (code == drc_pkg::HOLD_TOP) begin
			hold_len = HOLD_LONG_PERIODS; // see (R6)
		end else begin
			// codes 9..13 continue doubling up to 131072; code 14 overflows 18 bits to 0
			hold_len = drc_pkg::HOLD_BASE << (code - 4'h1); // see (R5) see (R6)
		end
	endfunction : hold_len

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ctrl_one;
	logic [3:0] hold_code;
	wire wr_ctrl = reg_req_in.wr && reg_req_in.addr == drc_pkg::ADDR_CTRL_ONE;
	wire wr_hold = reg_req_in.wr && reg_req_in.addr == drc_pkg::ADDR_HOLD_CTRL;
	wire [7:0] hold_read = {1'b0, hold_code, drc_pkg::HOLD_LOW_RSVD}; // see (R8)
	wire [7:0] next_rdata =
		(reg_req_in.addr == drc_pkg::ADDR_CTRL_ONE) ? ctrl_one :
		(reg_req_in.addr == drc_pkg::ADDR_HOLD_CTRL) ? hold_read :
		drc_pkg::READ_UNMAPPED;

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			ctrl_one <= drc_pkg::CTRL_ONE_RESET; // see (R3) see (R4)
			hold_code <= drc_pkg::HOLD_CODE_RESET; // see (R7)
		end else begin
			if (wr_ctrl) begin
				ctrl_one <= reg_req_in.data;
			end
			if (wr_hold) begin
				// only the hold field is writable; the rest reads fixed
				hold_code <= reg_req_in.data[drc_pkg::HOLD_LSB +: 4];
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= drc_pkg::READ_UNMAPPED;
		end else if (reg_req_in.rd) begin
			reg_rdata_out <= next_rdata;
		end
	end

	wire en_left = ctrl_one[drc_pkg::BIT_EN_LEFT];
	wire en_right = ctrl_one[drc_pkg::BIT_EN_RIGHT];
	drc_pkg::drc_cfg_t cfg;
	assign cfg.thr_db = thr_db(ctrl_one[drc_pkg::THR_LSB +: 3]);
	assign cfg.hyst_db = {6'h00, ctrl_one[drc_pkg::HYST_LSB +: 2]}; // see (R4)
	assign cfg.hold_len = hold_len(hold_code);

	// ----------------------------------------
	// word clock from the pin
	// ----------------------------------------
	logic [2:0] wclk_sync;
	logic wclk_stable;
	wire wclk_agree = wclk_sync[1] == wclk_sync[2];
	wire word_tick = wclk_agree && wclk_sync[2] && !wclk_stable;

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			wclk_sync <= 3'h0;
			wclk_stable <= 1'b0;
		end else begin
			wclk_sync <= {wclk_sync[1:0], word_clk_in};
			if (wclk_agree) begin
				wclk_stable <= wclk_sync[2];
			end
		end
	end

	// ----------------------------------------
	// volume linking
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			vol_link_out <= drc_pkg::VOL_LINK_INDEP;
		end else begin
			// any enabled channel forces independent volumes
			vol_link_out <= (en_left || en_right) ?
				drc_pkg::VOL_LINK_INDEP : vol_link_in; // see (R9)
		end
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	drc_channel #(
		.SAMPLE_W(SAMPLE_W)
	) u_left (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.enable_in(en_left), // see (R1)
		.cfg_in(cfg),
		.word_tick_in(word_tick),
		.sample_vld_in(sample_vld_in),
		.sample_in(left_sample_in),
		.level_db_in(left_level_db_in),
		.sample_out(left_sample_out),
		.sample_vld_out(sample_vld_out),
		.active_out(comp_active_out[drc_pkg::CH_LEFT])
	);

	drc_channel #(
		.SAMPLE_W(SAMPLE_W)
	) u_right (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.enable_in(en_right), // see (R2)
		.cfg_in(cfg),
		.word_tick_in(word_tick),
		.sample_vld_in(sample_vld_in),
		.sample_in(right_sample_in),
		.level_db_in(right_level_db_in),
		.sample_out(right_sample_out),
		.sample_vld_out(),
		.active_out(comp_active_out[drc_pkg::CH_RIGHT])
	);
endmodule : drc_cfg_top

// ===== rtl/drc_channel.sv
`timescale 1ns/100ps
module drc_channel #(
	parameter int SAMPLE_W = 16
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input wire drc_pkg::drc_cfg_t cfg_in,
	input wire logic word_tick_in,
	input wire logic sample_vld_in,
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic [7:0] level_db_in,
	output logic [SAMPLE_W-1:0] sample_out,
	output logic sample_vld_out,
	output logic active_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_COMP = 3'b010,
		ST_HOLD = 3'b100
	} drc_ch_state_t;

	drc_ch_state_t state;
	drc_ch_state_t next_state;
	logic [17:0] hold_cnt;
	logic [17:0] next_hold_cnt;
	logic [8:0] release_db;
	wire over = level_db_in < cfg_in.thr_db;
	wire released;
	wire hold_done = hold_cnt == 18'h00000;

	// release needs level below threshold minus hysteresis
	assign release_db = {1'b0, cfg_in.thr_db} + {1'b0, cfg_in.hyst_db};
	assign released = {1'b0, level_db_in} > release_db;

	// ----------------------------------------
	// gain-reduction sequencing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		unique case (state)
			ST_IDLE: begin
				if (sample_vld_in && over) begin
					next_state = ST_COMP; // see (R10)
				end
			end
			ST_COMP: begin
				if (sample_vld_in && released) begin
					next_hold_cnt = cfg_in.hold_len;
					if (cfg_in.hold_len == 18'h00000) begin
						next_state = ST_IDLE; // see (R5)
					end else begin
						next_state = ST_HOLD; // see (R10)
					end
				end
			end
			ST_HOLD: begin
				if (sample_vld_in && !released) begin
					next_state = ST_COMP;
				end else if (hold_done) begin
					next_state = ST_IDLE; // see (R10)
				end else if (word_tick_in) begin
					next_hold_cnt = hold_cnt - 18'h00001;
				end
			end
		endcase
		if (!enable_in) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			state <= ST_IDLE;
			hold_cnt <= 18'h00000;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
		end
	end

	// fixed 6 dB cut; the gain curve itself lives elsewhere
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			sample_out <= '0;
			sample_vld_out <= 1'b0;
			active_out <= 1'b0;
		end else begin
			sample_vld_out <= sample_vld_in;
			active_out <= next_state != ST_IDLE;
			if (sample_vld_in) begin
				sample_out <= (enable_in && state != ST_IDLE) ?
					SAMPLE_W'($signed(sample_in) >>> 1) :
					sample_in; // see (R1) see (R2)
			end
		end
	end
endmodule : drc_channel

// ===== rtl/drc_pkg.sv
package drc_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h44;
	localparam logic [7:0] ADDR_HOLD_CTRL = 8'h46;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h0F;
	localparam logic [3:0] HOLD_CODE_RESET = 4'h7;
	localparam int BIT_RSVD = 7;
	localparam int BIT_EN_LEFT = 6;
	localparam int BIT_EN_RIGHT = 5;
	localparam int THR_LSB = 2;
	localparam int HYST_LSB = 0;
	localparam int HOLD_LSB = 3;
	localparam logic [2:0] HOLD_LOW_RSVD = 3'h0;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// ----------------------------------------
	// decode constants
	// ----------------------------------------
	localparam logic [7:0] THR_STEP_DB = 8'h03;
	localparam logic [3:0] HOLD_OFF = 4'h0;
	localparam logic [3:0] HOLD_TOP = 4'hF;
	localparam logic [17:0] HOLD_BASE = 18'h00020;
	localparam logic [1:0] VOL_LINK_INDEP = 2'h0;
	localparam int CH_LEFT = 0;
	localparam int CH_RIGHT = 1;
	localparam int NUM_CH = 2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} drc_reg_req_t;

	typedef struct packed {
		logic [7:0] thr_db;
		logic [7:0] hyst_db;
		logic [17:0] hold_len;
	} drc_cfg_t;
endpackage : drc_pkg

// ===== tb/audio_dynamic_range_compressor_cfg_tb_top.sv
`timescale 1ns/100ps
module audio_dynamic_range_compressor_cfg_tb_top;
	logic mclk_in = 0, nrst_in = 0, word_clk_in = 0, vld = 0;
	logic [7:0] lvl = 8'h00, rdata, got;
	logic [1:0] link_out, active;
	logic [15:0] lout, rout;
	logic [3:0] codes [3] = '{4'h0, 4'h1, 4'hF};
	int lens [3] = '{0, 32, 64};
	drc_pkg::drc_reg_req_t req;
	int n_fail = 0, checks_done = 0;
	drc_host_model i_host (.mclk_in(mclk_in), .rdata_in(rdata), .req_out(req));
	// code 15 shortened to 64 ticks to keep the run brief
	drc_cfg_top #(.HOLD_LONG_PERIODS(18'h00040)) i_dut (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_req_in(req),
		.reg_rdata_out(rdata), .word_clk_in(word_clk_in),
		.vol_link_in(2'h1), .vol_link_out(link_out),
		.sample_vld_in(vld), .left_sample_in(16'h8004),
		.right_sample_in(16'h1234), .left_level_db_in(lvl),
		.right_level_db_in(lvl), .left_sample_out(lout),
		.right_sample_out(rout), .sample_vld_out(),
		.comp_active_out(active));
	initial forever #25 mclk_in = ~mclk_in;
	initial forever #100 word_clk_in = ~word_clk_in;
	task automatic cmp(input string what, input logic [15:0] exp, seen);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, exp, seen);
		end
	endtask : cmp
	task automatic test_done;
		if (n_fail == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic smp(input logic [7:0] l);
		@(negedge mclk_in);
		vld = 1'b1;
		lvl = l;
		@(negedge mclk_in);
		vld = 1'b0;
	endtask : smp
	// sync lag covered by the trailing mclk cycles
	task automatic ticks(input int n);
		repeat (n) @(posedge word_clk_in);
		repeat (5) @(negedge mclk_in);
	endtask : ticks
	initial begin
		#3ms;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (5) @(negedge mclk_in);
		nrst_in = 1'b1;
		i_host.rd(8'h44, got);
		cmp("ctrl", 16'h000F, {8'h00, got});
		i_host.rd(8'h46, got);
		cmp("hold", 16'h0038, {8'h00, got});
		i_host.rd(8'h45, got);
		cmp("unmapped", 16'h0000, {8'h00, got});
		cmp("link", 16'h0001, {14'h0, link_out});
		i_host.wr(8'h44, 8'h4F);
		smp(8'h0C);
		cmp("active", 16'h0000, {14'h0, active});
		cmp("link", 16'h0000, {14'h0, link_out});
		smp(8'h0B);
		cmp("active", 16'h0001, {14'h0, active});
		smp(8'h05);
		cmp("left", 16'hC002, lout);
		cmp("right", 16'h1234, rout);
		smp(8'h0F);
		cmp("active", 16'h0001, {14'h0, active});
		foreach (codes[i]) begin
			i_host.wr(8'h46, {1'b0, codes[i], 3'h0});
			smp(8'h05);
			smp(8'h14);
			if (lens[i] > 2) begin
				ticks(lens[i] - 2);
				cmp("held", 16'h0001, {14'h0, active});
			end
			ticks(4);
			cmp("released", 16'h0000, {14'h0, active});
		end
		i_host.wr(8'h44, 8'h2F);
		smp(8'h05);
		smp(8'h05);
		cmp("left", 16'h8004, lout);
		cmp("right", 16'h091A, rout);
		cmp("active", 16'h0002, {14'h0, active});
		test_done();
	end
endmodule : audio_dynamic_range_compressor_cfg_tb_top

// ===== tb/drc_cfg_checker.sv
`timescale 1ns/100ps
module drc_cfg_checker #(
	parameter int SAMPLE_W = 16
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire drc_pkg::drc_reg_req_t reg_req_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic sample_vld_in,
	input wire logic [SAMPLE_W-1:0] left_sample_in,
	input wire logic [SAMPLE_W-1:0] right_sample_in,
	input wire logic [SAMPLE_W-1:0] left_sample_out,
	input wire logic [SAMPLE_W-1:0] right_sample_out,
	input wire logic sample_vld_out,
	input wire logic [1:0] comp_active_out
);
	localparam int M = SAMPLE_W - 1;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	wire rd_unmapped = reg_req_in.rd && reg_req_in.addr != 8'h44
		&& reg_req_in.addr != 8'h46;
	chk_vld_delay: assert property (sample_vld_in |=> sample_vld_out)
		else $error("valid out missing");
	chk_unmapped_zero: assert property (rd_unmapped |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	chk_hold_rsvd: assert property (reg_req_in.rd && reg_req_in.addr == 8'h46
		|=> reg_rdata_out[2:0] == 3'h0 && !reg_rdata_out[7])
		else $error("reserved hold bits not zero");
	chk_left_pass: assert property (sample_vld_in && !comp_active_out[0]
		|=> left_sample_out == $past(left_sample_in))
		else $error("left altered while idle");
	chk_left_comp: assert property (sample_vld_in && comp_active_out[0]
		|=> left_sample_out == {$past(left_sample_in[M]),
		$past(left_sample_in[M:1])})
		else $error("left not compressed");
	chk_right_pass: assert property (sample_vld_in && !comp_active_out[1]
		|=> right_sample_out == $past(right_sample_in))
		else $error("right altered while idle");
	chk_right_comp: assert property (sample_vld_in && comp_active_out[1]
		|=> right_sample_out == {$past(right_sample_in[M]),
		$past(right_sample_in[M:1])})
		else $error("right not compressed");
	chk_start_on_vld: assert property ($rose(comp_active_out[0])
		|-> $past(sample_vld_in))
		else $error("left started without sample");
	cover property (sample_vld_in && comp_active_out[0]);
	cover property (sample_vld_in && comp_active_out[1]);
	cover property (rd_unmapped);
endmodule : drc_cfg_checker
bind drc_cfg_top drc_cfg_checker #(.SAMPLE_W(SAMPLE_W)) i_chk (
	.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_req_in(reg_req_in),
	.reg_rdata_out(reg_rdata_out), .sample_vld_in(sample_vld_in),
	.left_sample_in(left_sample_in), .right_sample_in(right_sample_in),
	.left_sample_out(left_sample_out), .right_sample_out(right_sample_out),
	.sample_vld_out(sample_vld_out), .comp_active_out(comp_active_out));

// ===== tb/drc_host_model.sv
`timescale 1ns/100ps
module drc_host_model (
	input wire logic mclk_in,
	input wire logic [7:0] rdata_in,
	output drc_pkg::drc_reg_req_t req_out
);
	initial req_out = '0;
	// one-cycle strobe, launched and dropped on falling edges
	task automatic put(input logic w, input logic [7:0] a, d);
		@(negedge mclk_in);
		req_out = '{wr: w, rd: !w, addr: a, data: d};
		@(negedge mclk_in);
		req_out = '0;
	endtask : put
	task automatic wr(input logic [7:0] a, d);
		put(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		put(1'b0, a, 8'h00);
		d = rdata_in;
	endtask : rd
endmodule : drc_host_model
